// *** dv/feeo_field_model.sv ***
// Field side of the block: level transducers, float contacts and the clock of day.
// Assumes every output changes just after a rising edge of aclk.
`timescale 1ns/100ps
module feeo_field_model (
  // Clock
  input  wire logic          aclk,
  // Field signals
  output logic               level_valid,
  output logic signed [31:0] level_v,
  output logic [15:0]        discrete_in,
  output logic [4:0]         tod_hour,
  output logic [5:0]         tod_minute
);
  initial begin
    level_valid = 1'b0;
    level_v = 32'sh0;
    discrete_in = 16'h0000;
    tod_hour = 5'h00;
    tod_minute = 6'h00;
  end
  // The reading is only good while valid is high, so it is scrambled afterwards.
  task automatic sample(input logic signed [31:0] v);
    @(posedge aclk);
    level_v <= v;
    level_valid <= 1'b1;
    @(posedge aclk);
    level_v <= ~v;
    level_valid <= 1'b0;
  endtask
  task automatic pins(input logic [15:0] d, input logic [4:0] h, input logic [5:0] m);
    @(posedge aclk);
    discrete_in <= d;
    tod_hour <= h;
    tod_minute <= m;
  endtask
endmodule

// *** dv/flow_event_energy_override_test.sv ***
// Self-checking bench of the flow event and energy override block.
// Assumes the field model drives all measurements; registers are reached over AXI4-Lite.
`timescale 1ns/100ps
module flow_event_energy_override_test;
  import feeo_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        level_valid;
  logic signed [31:0] level_v;
  logic [15:0] discrete_in;
  logic [4:0]  tod_hour, tod_alarm_trip;
  logic [5:0]  tod_minute;
  feeo_flow_t  flow_condition_status;
  logic [NUM_RELAYS-1:0][1:0] override_status_code;
  int          num_errors = 0, check_count = 0, cyc = 0;
  logic [31:0] src[8], trg[8], rel[8], lv[8], cl[8];
  logic [1:0]  ex[8], oc;

  feeo_field_model fm (.aclk, .level_valid, .level_v, .discrete_in, .tod_hour, .tod_minute);
  feeo_top #(.CYCLES_PER_SEC(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .level_valid,
    // Each point reads a different value, so a wrong point choice shows; a wrong kind shows at points 1 and 3, not at point 2.
    .level_1(level_v), .level_2(-level_v), .level_combined(level_v + 32'sd1000),
    .rate_1(level_v + 32'sd1000), .rate_2(-level_v), .rate_combined(level_v),
    .discrete_in, .tod_hour, .tod_minute,
    .flow_condition_status, .override_status_code, .tod_alarm_trip, .irq);

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready is sampled at the falling edge; it only moves on rising edges.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, t;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(negedge aclk);
      t = s_axi_awvalid & s_axi_awready;
      da |= t;
      dw |= s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end while (!(da && dw));
    do begin
      @(negedge aclk);
      {t, r} = {s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
    end while (!t);
    s_axi_bready <= 1'b0;
    chk("bresp", RESP_OKAY, r);
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      {t, rd_d, rd_r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset;
    rd(OFS_SOURCE);
    chk("source", 32'h0, rd_d);
    rd(OFS_TIMING);
    chk("timing", {MAX_DUR_RST_S, DEBOUNCE_RST_S}, rd_d);
    rd(8'h30);
    chk("unmapped", {30'h0, RESP_SLVERR}, {rd_d[29:0], rd_r});
    chk("flow", FLOW_NORMAL, flow_condition_status);
  endtask
  task automatic t_levels;
    src = '{32'h101, 32'h101, 32'h203, 32'h105, 32'h206, 32'h001, 32'h301, 32'h301};
    trg = '{32'd100, 32'd50, 32'd50, 32'd100, -32'sd100, 32'd100, 32'd100, 32'd100};
    rel = '{32'd50, 32'd100, 32'd100, 32'd50, -32'sd50, 32'd50, 32'd50, 32'd50};
    lv = '{32'd120, 32'd200, 32'd60, -32'sd500, 32'd120, 32'd120, 32'd120, -32'sd500};
    cl = '{32'd0, 32'd0, -32'sd200, -32'sd1000, 32'd0, 32'd0, 32'd0, -32'sd1000};
    ex = '{FLOW_OVER, FLOW_NORMAL, FLOW_UNDER, FLOW_OVER, FLOW_UNDER, FLOW_NORMAL,
           FLOW_NORMAL, FLOW_OVER};
    for (int i = 0; i < 8; i++) begin
      if (i == 7) wr(OFS_CONFIG, {24'h0, OP_DUAL_A});
      wr(OFS_SOURCE, src[i]);
      wr(OFS_TRIGGER, trg[i]);
      wr(OFS_RELEASE, rel[i]);
      fm.sample(lv[i]);
      @(negedge aclk);
      chk("flow", ex[i], flow_condition_status);
      oc = {1'b0, ex[i] != 2'h0};
      chk("ovr", {26'h0, oc, 2'h0, oc}, override_status_code[2:0]);
      chk("ovr3", 2'h0, override_status_code[3]);
      fm.sample(cl[i]);
      @(negedge aclk);
      chk("flow clear", FLOW_NORMAL, flow_condition_status);
    end
    chk("irq", 1'b1, irq);
    rd(OFS_IRQ_STATUS);
    chk("irq bit", 1'b1, rd_d[IRQ_OVER]);
    settle(1);
    chk("irq", 1'b0, irq);
  endtask
  task automatic t_manual;
    wr(OFS_SOURCE, 32'h502);
    wr(OFS_TRIGGER, 32'h0);
    wr(OFS_MANUAL, 32'h9);
    fm.pins(16'h0100, 5'h00, 6'h00);
    settle(8);
    chk("manual", {2'h0, 2'h2}, override_status_code[1:0]);
    chk("flow", FLOW_NORMAL, flow_condition_status);
    fm.pins(16'h0110, 5'h00, 6'h00);
    settle(8);
    chk("flow", FLOW_OVER, flow_condition_status);
    chk("both", 2'h3, override_status_code[0]);
    fm.pins(16'h0010, 5'h00, 6'h00);
    settle(8);
    chk("nolatch", 2'h1, override_status_code[0]);
    fm.pins(16'h0000, 5'h00, 6'h00);
    settle(20);
    chk("debounce hold", FLOW_OVER, flow_condition_status);
    settle(50);
    chk("debounce", FLOW_NORMAL, flow_condition_status);
    wr(OFS_TIMING, {16'h0002, DEBOUNCE_RST_S});
    fm.pins(16'h0010, 5'h00, 6'h00);
    settle(8);
    chk("set again", FLOW_OVER, flow_condition_status);
    settle(35);
    chk("max duration", FLOW_NORMAL, flow_condition_status);
  endtask
  task automatic t_tod;
    for (int m = 29; m < 32; m++) begin
      fm.pins(16'h0000, 5'h05, 6'(m));
      settle(3);
      chk("trip", (m == 30) ? 5'h02 : 5'h00, tod_alarm_trip);
    end
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    wr(OFS_RELAY_BASE, 32'h32);
    wr(OFS_RELAY_BASE + 8'h04, 32'h001E0509);
    wr(OFS_RELAY_BASE + 8'h08, 32'h38);
    wr(OFS_RELAY_BASE + 8'h0C, 32'h39);
    wr(OFS_IRQ_MASK, 32'h1);
    t_levels();
    t_manual();
    t_tod();
    print_verdict();
  end
endmodule

// *** logic/feeo_pkg.sv ***
// Constants of the flow event and energy override block.
// Assumes a 100 MHz clock and an AXI4-Lite master with 8-bit byte addresses.
package feeo_pkg;
  localparam int NUM_RELAYS = 5;
  localparam int NUM_DIN    = 16;
  localparam int IRQ_W      = 3 + NUM_RELAYS;
  // Register byte offsets.
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_SOURCE     = 8'h04;
  localparam logic [7:0] OFS_TRIGGER    = 8'h08;
  localparam logic [7:0] OFS_RELEASE    = 8'h0C;
  localparam logic [7:0] OFS_MANUAL     = 8'h10;
  localparam logic [7:0] OFS_TIMING     = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;
  localparam logic [7:0] OFS_RELAY_BASE = 8'h40;
  // Field positions.
  localparam int SRC_POINT_LSB = 8;
  localparam int TIM_MAX_LSB   = 16;
  localparam int RLY_HOUR_LSB  = 8;
  localparam int RLY_MIN_LSB   = 16;
  localparam int STAT_OVR_LSB  = 8;
  localparam int IRQ_OVER      = 0;
  localparam int IRQ_UNDER     = 1;
  localparam int IRQ_CLEARED   = 2;
  localparam int IRQ_TOD_LSB   = 3;
  // Reset values.
  localparam logic [15:0] DEBOUNCE_RST_S = 16'h0005;
  localparam logic [15:0] MAX_DUR_RST_S  = 16'h0168;
  // Codes.
  localparam logic [3:0] SRC_OVER_LEVEL  = 4'h1;
  localparam logic [3:0] SRC_OVER_DISC   = 4'h2;
  localparam logic [3:0] SRC_UNDER_LEVEL = 4'h3;
  localparam logic [3:0] SRC_UNDER_DISC  = 4'h4;
  localparam logic [3:0] SRC_OVER_RATE   = 4'h5;
  localparam logic [3:0] SRC_UNDER_RATE  = 4'h6;
  localparam logic [4:0] POINT_XDCR_1    = 5'h01;
  localparam logic [4:0] POINT_XDCR_2    = 5'h02;
  localparam logic [4:0] POINT_COMBINED  = 5'h03;
  localparam logic [4:0] POINT_DISC_MAX  = 5'h10;
  localparam logic [7:0] OP_DUAL_A       = 8'h04;
  localparam logic [7:0] OP_DUAL_B       = 8'h05;
  localparam logic [7:0] FUNC_TOD_ALARM  = 8'h09;
  localparam logic [7:0] FUNC_PUMP_MIN   = 8'h32;
  localparam logic [7:0] FUNC_PUMP_MAX   = 8'h38;
  localparam logic [4:0] HOUR_MAX        = 5'h17;
  localparam logic [5:0] MINUTE_MAX      = 6'h3B;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // Timing.
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint SECOND_NS     = 1000000000;
  localparam int     SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    FLOW_NORMAL = 2'h0,
    FLOW_OVER   = 2'h1,
    FLOW_UNDER  = 2'h2
  } feeo_flow_t;
endpackage

// *** logic/feeo_top.sv ***
// Flow event detection, energy override status and time-of-day alarm trips.
// Assumes levels, rates and time of day come from logic on aclk; discrete pins are async.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// - Time alarm relay trips at its hour:minute.
// - Override applies only to pump codes 50-56.
// - Manual select: 0 off, 1-16 pick input.
// - Manual override follows input level, never latches.
// - Status code: flow bit0, manual bit1.
// - Override on flow condition or manual input.
// - Source type codes 1..6 choose event kind.
// - Point 3 of a level or rate source valid only in dual operation.
// - Discrete points pick base or expansion inputs.
// - Zero type or point disables detection.
// - Thresholds ignored for discrete sources.
// - Overflow needs trigger above release.
// - Underflow needs release above trigger.
// - Rate sources compare signed rates.
// - Detected condition sets flow status.
// - Flow status: 0 normal, 1 over, 2 under.
// - Clear on release, debounce, or max duration.
module feeo_top #(
  parameter int CYCLES_PER_SEC = feeo_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]                       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Measurements
  input  wire logic                             level_valid,
  input  wire logic signed [31:0]               level_1,
  input  wire logic signed [31:0]               level_2,
  input  wire logic signed [31:0]               level_combined,
  input  wire logic signed [31:0]               rate_1,
  input  wire logic signed [31:0]               rate_2,
  input  wire logic signed [31:0]               rate_combined,
  input  wire logic [feeo_pkg::NUM_DIN-1:0]     discrete_in,
  input  wire logic [4:0]                       tod_hour,
  input  wire logic [5:0]                       tod_minute,
  // Decisions
  output feeo_pkg::feeo_flow_t                  flow_condition_status,
  output logic [feeo_pkg::NUM_RELAYS-1:0][1:0]  override_status_code,
  output logic [feeo_pkg::NUM_RELAYS-1:0]       tod_alarm_trip,
  output logic                                  irq
);
  import feeo_pkg::*;

  typedef struct packed {
    logic [NUM_DIN-1:0]               din_s1, din_s2, din_s3, din_f;
    logic [26:0]                      sec_cnt;
    logic                             sec_tick;
    logic [7:0]                       op_sel;
    logic [3:0]                       src_type;
    logic [4:0]                       src_point;
    logic signed [31:0]               trig, rel;
    logic [4:0]                       man_sel;
    logic [15:0]                      deb_lim, max_lim, deb_cnt, dur_cnt;
    feeo_flow_t                       flow;
    logic                             spent;
    logic [NUM_RELAYS-1:0][7:0]       func;
    logic [NUM_RELAYS-1:0][4:0]       hour;
    logic [NUM_RELAYS-1:0][5:0]       minute;
    logic [NUM_RELAYS-1:0][1:0]       ovr;
    logic [NUM_RELAYS-1:0]            trip;
    logic [IRQ_W-1:0]                 irq_st, irq_mask;
    logic                             irq;
    logic                             awready, aw_held;
    logic [7:0]                       awaddr;
    logic                             wready, w_held;
    logic [31:0]                      wdata;
    logic [3:0]                       wstrb;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready, rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
  } feeo_state_t;
  feeo_state_t s_q, s_d;

  // Register image at a byte address; ok is low for an unmapped address.
  function automatic logic [32:0] reg_image(input logic [7:0] a, input feeo_state_t s);
    logic [31:0] v;
    logic        ok;
    logic [2:0]  ri;
    v  = 32'h0000_0000;
    ok = 1'b1;
    ri = 3'((a - OFS_RELAY_BASE) >> 2);
    case (a)
      OFS_CONFIG:     v[7:0] = s.op_sel;
      OFS_SOURCE:     v = {19'h0, s.src_point, 4'h0, s.src_type};
      OFS_TRIGGER:    v = s.trig;
      OFS_RELEASE:    v = s.rel;
      OFS_MANUAL:     v[4:0] = s.man_sel;
      OFS_TIMING:     v = {s.max_lim, s.deb_lim};
      OFS_STATUS:     v = {14'h0, s.ovr, 6'h0, s.flow};
      OFS_IRQ_STATUS: v[IRQ_W-1:0] = s.irq_st;
      OFS_IRQ_MASK:   v[IRQ_W-1:0] = s.irq_mask;
      default: begin
        if (a >= OFS_RELAY_BASE && a[1:0] == 2'h0 && int'(ri) < NUM_RELAYS &&
            a < OFS_RELAY_BASE + 8'h20) begin
          v = {10'h0, s.minute[ri], 3'h0, s.hour[ri], s.func[ri]};
        end else begin
          ok = 1'b0;
        end
      end
    endcase
    return {ok, v};
  endfunction

  // Per-relay decode.
  logic [NUM_RELAYS-1:0] is_pump, tod_hit;
  for (genvar i = 0; i < NUM_RELAYS; i++) begin : g_relay
    assign is_pump[i] = s_q.func[i] >= FUNC_PUMP_MIN && s_q.func[i] <= FUNC_PUMP_MAX;
    assign tod_hit[i] = s_q.func[i] == FUNC_TOD_ALARM && s_q.hour[i] <= HOUR_MAX &&
                        s_q.minute[i] <= MINUTE_MAX && tod_hour == s_q.hour[i] &&
                        tod_minute == s_q.minute[i];
  end

  // Source decode.
  logic               is_disc, is_rate, is_over, is_under, point_ok, cfg_ok;
  logic signed [31:0] meas;
  logic [3:0]         dpt, mpt;
  logic               man_act, cond_on, past_rel, eval;

  always_comb begin
    is_disc  = s_q.src_type == SRC_OVER_DISC || s_q.src_type == SRC_UNDER_DISC;
    is_rate  = s_q.src_type == SRC_OVER_RATE || s_q.src_type == SRC_UNDER_RATE;
    is_over  = s_q.src_type == SRC_OVER_LEVEL || s_q.src_type == SRC_OVER_DISC ||
               s_q.src_type == SRC_OVER_RATE;
    is_under = s_q.src_type == SRC_UNDER_LEVEL || s_q.src_type == SRC_UNDER_DISC ||
               s_q.src_type == SRC_UNDER_RATE;
    dpt      = 4'(s_q.src_point - 5'h01);
    mpt      = 4'(s_q.man_sel - 5'h01);
    if (is_disc) begin
      point_ok = s_q.src_point <= POINT_DISC_MAX;
    end else begin
      point_ok = s_q.src_point == POINT_XDCR_1 || s_q.src_point == POINT_XDCR_2 ||
                 (s_q.src_point == POINT_COMBINED &&
                  (s_q.op_sel == OP_DUAL_A || s_q.op_sel == OP_DUAL_B));
    end
    // Rates are signed like levels, so one comparator serves both kinds.
    case (s_q.src_point)
      POINT_XDCR_1: meas = is_rate ? rate_1 : level_1;
      POINT_XDCR_2: meas = is_rate ? rate_2 : level_2;
      default:      meas = is_rate ? rate_combined : level_combined;
    endcase
    cfg_ok = s_q.src_type != 4'h0 && s_q.src_point != 5'h00 && point_ok &&
             (is_over || is_under) &&
             (is_disc || (is_over ? s_q.trig > s_q.rel : s_q.rel > s_q.trig));
    if (is_disc) begin
      cond_on  = s_q.din_f[dpt];
      past_rel = ~s_q.din_f[dpt];
    end else begin
      cond_on  = is_over ? meas >= s_q.trig : meas <= s_q.trig;
      past_rel = is_over ? meas < s_q.rel : meas > s_q.rel;
    end
    eval    = is_disc | level_valid;
    man_act = s_q.man_sel != 5'h00 && s_q.man_sel <= POINT_DISC_MAX && s_q.din_f[mpt];
  end

  logic [32:0]      wimg, rimg;
  logic [31:0]      wm, wv;
  logic [IRQ_W-1:0] ev, rdclr;
  logic [2:0]       wri;
  logic             end_flow;

  always_comb begin
    s_d      = s_q;
    ev       = '0;
    rdclr    = '0;
    end_flow = 1'b0;
    wimg     = reg_image(s_q.awaddr, s_q);
    rimg     = reg_image(s_axi_araddr, s_q);
    wri      = 3'((s_q.awaddr - OFS_RELAY_BASE) >> 2);
    for (int b = 0; b < 4; b++) begin
      wm[8*b +: 8] = {8{s_q.wstrb[b]}};
    end
    wv = (wimg[31:0] & ~wm) | (s_q.wdata & wm);
    // The first stage feeds only the second; a change counts once stages two and three agree.
    s_d.din_s1 = discrete_in;
    s_d.din_s2 = s_q.din_s1;
    s_d.din_s3 = s_q.din_s2;
    s_d.din_f  = (s_q.din_s2 & s_q.din_s3) | (s_q.din_f & (s_q.din_s2 ^ s_q.din_s3));
    s_d.sec_tick = s_q.sec_cnt == 27'(CYCLES_PER_SEC - 1);
    s_d.sec_cnt  = s_d.sec_tick ? 27'h0000000 : s_q.sec_cnt + 27'h0000001;
    // Flow condition. Debounce and duration run in whole seconds of the free tick.
    if (!cfg_ok) begin
      s_d.flow  = FLOW_NORMAL;
      s_d.spent = 1'b0;
    end else if (s_q.flow == FLOW_NORMAL) begin
      if (eval && !cond_on) begin
        s_d.spent = 1'b0;
      end
      if (eval && cond_on && !s_q.spent) begin
        s_d.flow    = is_over ? FLOW_OVER : FLOW_UNDER;
        s_d.dur_cnt = 16'h0000;
        s_d.deb_cnt = 16'h0000;
        ev[is_over ? IRQ_OVER : IRQ_UNDER] = 1'b1;
      end
    end else begin
      if (s_q.sec_tick) begin
        s_d.dur_cnt = s_q.dur_cnt + 16'h0001;
      end
      if (is_disc) begin
        if (cond_on) begin
          s_d.deb_cnt = 16'h0000;
        end else if (s_q.deb_lim == 16'h0000) begin
          end_flow = 1'b1;
        end else if (s_q.sec_tick) begin
          s_d.deb_cnt = s_q.deb_cnt + 16'h0001;
          end_flow    = s_d.deb_cnt >= s_q.deb_lim;
        end
      end else if (eval && past_rel) begin
        end_flow = 1'b1;
      end
      // A condition cut short by its duration limit must go away before it may return.
      if (s_q.max_lim != 16'h0000 && s_d.dur_cnt >= s_q.max_lim) begin
        end_flow  = 1'b1;
        s_d.spent = 1'b1;
      end
      if (end_flow) begin
        s_d.flow            = FLOW_NORMAL;
        ev[IRQ_CLEARED]     = 1'b1;
      end
    end
    for (int i = 0; i < NUM_RELAYS; i++) begin
      s_d.ovr[i]  = is_pump[i] ? {man_act, s_d.flow != FLOW_NORMAL} : 2'h0;
      s_d.trip[i] = tod_hit[i];
      ev[IRQ_TOD_LSB + i] = tod_hit[i] & ~s_q.trip[i];
    end
    // AXI4-Lite write: address and data taken in either order, one write at a time.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.aw_held = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wready = 1'b0;
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wimg[32] ? RESP_OKAY : RESP_SLVERR;
      case (s_q.awaddr)
        OFS_CONFIG:     s_d.op_sel = wv[7:0];
        OFS_SOURCE: begin
          s_d.src_type  = wv[3:0];
          s_d.src_point = wv[SRC_POINT_LSB +: 5];
        end
        OFS_TRIGGER:    s_d.trig = wv;
        OFS_RELEASE:    s_d.rel = wv;
        OFS_MANUAL:     s_d.man_sel = wv[4:0];
        OFS_TIMING: begin
          s_d.deb_lim = wv[15:0];
          s_d.max_lim = wv[TIM_MAX_LSB +: 16];
        end
        OFS_IRQ_MASK:   s_d.irq_mask = wv[IRQ_W-1:0];
        default: begin
          if (wimg[32] && s_q.awaddr >= OFS_RELAY_BASE) begin
            s_d.func[wri]   = wv[7:0];
            s_d.hour[wri]   = wv[RLY_HOUR_LSB +: 5];
            s_d.minute[wri] = wv[RLY_MIN_LSB +: 6];
          end
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end
    // AXI4-Lite read; reading the event status clears what was shown.
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rimg[31:0];
      s_d.rresp   = rimg[32] ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFS_IRQ_STATUS) begin
        rdclr = s_q.irq_st;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    // A new event wins over a clear in the same cycle.
    s_d.irq_st = (s_q.irq_st & ~rdclr) | ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.deb_lim <= DEBOUNCE_RST_S;
      s_q.max_lim <= MAX_DUR_RST_S;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready         = s_q.awready;
  assign s_axi_wready          = s_q.wready;
  assign s_axi_bvalid          = s_q.bvalid;
  assign s_axi_bresp           = s_q.bresp;
  assign s_axi_arready         = s_q.arready;
  assign s_axi_rvalid          = s_q.rvalid;
  assign s_axi_rdata           = s_q.rdata;
  assign s_axi_rresp           = s_q.rresp;
  assign flow_condition_status = s_q.flow;
  assign override_status_code  = s_q.ovr;
  assign tod_alarm_trip        = s_q.trip;
  assign irq                   = s_q.irq;

  a_tod_trip_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.func[1] == FUNC_TOD_ALARM && tod_hour == s_q.hour[1] && tod_minute == s_q.minute[1] &&
     s_q.hour[1] <= HOUR_MAX && s_q.minute[1] <= MINUTE_MAX) |=> tod_alarm_trip[1])
    else $error("time alarm did not trip");
  a_ovr_non_pump: assert property (@(posedge aclk) disable iff (!aresetn)
    !is_pump[1] |=> override_status_code[1] == 2'h0) else $error("override on non-pump relay");
  a_man_sel_off: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.man_sel == 5'h00 |=> !override_status_code[0][1]) else $error("manual override while off");
  a_man_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    is_pump[0] |=> override_status_code[0][1] == $past(man_act)) else $error("manual bit wrong");
  a_flow_bit_code: assert property (@(posedge aclk) disable iff (!aresetn)
    is_pump[2] ##1 is_pump[2] |-> override_status_code[2][0] == (s_q.flow != FLOW_NORMAL))
    else $error("flow bit of override code wrong");
  a_src_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.src_type == 4'h0 || s_q.src_point == 5'h00) |=> flow_condition_status == FLOW_NORMAL)
    else $error("flow active with disabled source");
  a_over_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.src_type == SRC_OVER_LEVEL && s_q.trig <= s_q.rel) |=> flow_condition_status == FLOW_NORMAL)
    else $error("overflow with bad threshold order");
  a_under_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.src_type == SRC_UNDER_RATE && s_q.rel <= s_q.trig) |=> flow_condition_status == FLOW_NORMAL)
    else $error("underflow with bad threshold order");
  a_disc_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_ok && is_disc && is_over && cond_on && !s_q.spent && s_q.flow == FLOW_NORMAL)
    |=> flow_condition_status == FLOW_OVER) else $error("discrete overflow not flagged");
  a_level_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_ok && !is_disc && level_valid && past_rel && s_q.flow != FLOW_NORMAL)
    |=> flow_condition_status == FLOW_NORMAL) else $error("flow not released");
  a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
